// ==== hw/tdc_pkg.sv ====
// Constants for the cassette tape command latch and decode block.
// Assumes one 100 MHz clock and a synchronous, active-high reset.
//
// Function
// - All data lines low gives motion high
// - Motion high for line 0,1,3; low 2
// - Direction high only for line one alone
// - Head mode high only for line zero alone
// - Drive outputs gated only by select and strobe
// - Auxiliary output high only for line three alone
// - Read selects 1/5/6 show position on line four
package tdc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int CMD_W  = 4;                       // Command data lines zero..three
    localparam int DATA_W = 8;                       // Parallel data bus lines
    localparam int ADDR_W = 8;                       // Register port address
    localparam int REG_W  = 32;                      // Register port data
    localparam int CNT_W  = 16;                      // Qualified write counter

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00; // Control
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04; // Latched command and drive sense
    localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h08; // Qualified command writes

    ////////////////////////////////////////////////////////////////////////////
    // Control fields and reset value
    localparam int CTRL_CNT_EN_BIT = 0;              // Count qualified writes
    localparam int CTRL_ACK_EN_BIT = 1;              // Allow acknowledge output
    localparam int CTRL_CLR_BIT    = 2;              // Write one: clear counter
    localparam logic [1:0] CTRL_RESET = 2'h3;        // Both enables on

    ////////////////////////////////////////////////////////////////////////////
    // Status fields
    localparam int ST_CMD_LSB    = 0;                // Latched command, 4 bits
    localparam int ST_MOTION_BIT = 4;                // Motion command output
    localparam int ST_DIR_BIT    = 5;                // Direction select output
    localparam int ST_HEAD_BIT   = 6;                // Head mode output
    localparam int ST_AUX_BIT    = 7;                // Auxiliary decoded output
    localparam int ST_POS_BIT    = 8;                // Tape position sense
    localparam int ST_WINH_BIT   = 9;                // Write inhibit sense
    localparam int ST_SIDE_BIT   = 10;               // Side sense
    localparam int ST_LOAD_BIT   = 11;               // Cassette loaded sense

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and data bus positions
    localparam logic [CMD_W-1:0] CMD_RESET = 4'h0;   // No lines: drive stopped
    localparam int POS_LINE  = 4;                    // Tape position on line four
    localparam int WINH_LINE = 5;                    // Write inhibit on line five
    localparam int SIDE_LINE = 6;                    // Side on line six
    localparam int LOAD_LINE = 7;                    // Cassette loaded on line seven
    localparam logic [DATA_W-1:0] SENSE_OE_N = 8'h0F; // Lines four..seven driven

endpackage

// ==== hw/tdc_decode.sv ====
// Command decoder: turns the four command data lines into drive levels.
// Assumes the caller registers the results; purely combinational here.
`timescale 1ns/1ns
`default_nettype none

module tdc_decode
    import tdc_pkg::*;
(
    input  wire logic [CMD_W-1:0] cmd,        // Command data lines zero..three
    output logic                  motion,     // Motion command level
    output logic                  direction,  // Direction select level
    output logic                  head_mode,  // Head mode level
    output logic                  aux         // Auxiliary decoded level
);

    ////////////////////////////////////////////////////////////////////////////
    // True when only the given line is high
    function automatic logic only_line(input logic [CMD_W-1:0] c, input int idx);
        logic [CMD_W-1:0] one;
        one = CMD_W'(1) << idx;
        return c == one;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Line two alone stops holding; everything else keeps motion high
    assign motion    = ~only_line(cmd, 2);
    assign direction = only_line(cmd, 1);
    assign head_mode = only_line(cmd, 0);
    assign aux       = only_line(cmd, 3);

endmodule

`default_nettype wire

// ==== hw/tdc_latch.sv ====
// Top of the tape interface command latch: host pin side, drive side,
// and a small software register port for control and status.
// Assumes all pin inputs are synchronous to clk; the host keeps the
// strobe high for at least one clock with select and data stable.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module tdc_latch
    import tdc_pkg::*;
(
    input  wire logic              clk,                  // 100 MHz clock
    input  wire logic              reset,                // Synchronous reset, high
    // Host parallel bus
    input  wire logic              dir_out,              // High: host writes out
    input  wire logic              iface_ctrl_line_zero, // Interface control 0
    input  wire logic              iface_ctrl_line_one,  // Interface control 1
    input  wire logic              iface_ctrl_line_two,  // Interface control 2
    input  wire logic              iface_ctrl_line_three,// Interface control 3
    input  wire logic              iface_ctrl_line_five, // Interface control 5
    input  wire logic              iface_ctrl_line_six,  // Interface control 6
    input  wire logic              ctrl_strobe,          // Control write strobe
    input  wire logic [DATA_W-1:0] data_line_in,         // Data lines as seen
    output logic      [DATA_W-1:0] data_line_out,        // Data lines driven value
    output logic      [DATA_W-1:0] data_line_oe_n,       // Low: line driven
    output logic                   ack,                  // Acknowledge
    // Tape drive side
    input  wire logic              tape_position,        // Tape position sense
    input  wire logic              write_inhibit,        // Write inhibit sense
    input  wire logic              side_select,          // Side A/B sense
    input  wire logic              cassette_loaded,      // Cassette present sense
    output logic                   tape_motion_command,  // High: tape held still
    output logic                   tape_direction_select,// High: rewind direction
    output logic                   tape_head_mode,       // High: write mode
    output logic                   tape_aux_decode,      // Auxiliary decoded line
    // Software register port
    input  wire logic [ADDR_W-1:0] reg_addr,             // Register byte address
    input  wire logic [REG_W-1:0]  reg_wdata,            // Write data
    input  wire logic              reg_write,            // Write strobe
    input  wire logic              reg_read,             // Read strobe
    output logic      [REG_W-1:0]  reg_rdata             // Read data, next cycle
);

    ////////////////////////////////////////////////////////////////////////////
    // Data line aliases
    logic [CMD_W-1:0] cmd_lines;                    // Data lines zero..three
    logic             data_line_zero;               // Command bit 0
    logic             data_line_one;                // Command bit 1
    logic             data_line_two;                // Command bit 2
    logic             data_line_three;              // Command bit 3

    assign cmd_lines       = data_line_in[CMD_W-1:0];
    assign data_line_zero  = cmd_lines[0];
    assign data_line_one   = cmd_lines[1];
    assign data_line_two   = cmd_lines[2];
    assign data_line_three = cmd_lines[3];

    ////////////////////////////////////////////////////////////////////////////
    // Interface select decode
    logic sel_cmd_write;                            // Tape command write select
    logic sel_sense_read;                           // Drive sense read select
    logic sel_aux_a;                                // Other select, in direction
    logic sel_aux_b;                                // Other select, out direction
    logic cmd_write_go;                             // Qualified command write
    logic sense_read_go;                            // Qualified sense read
    logic ack_go;                                   // Any recognised select

    // Host writes out with lines zero, five and six
    assign sel_cmd_write  = dir_out & iface_ctrl_line_zero
                          & iface_ctrl_line_five & iface_ctrl_line_six;
    // Host reads in with lines one, five and six
    assign sel_sense_read = ~dir_out & iface_ctrl_line_one
                          & iface_ctrl_line_five & iface_ctrl_line_six;
    // Further selects that only answer with acknowledge
    assign sel_aux_a      = ~dir_out & iface_ctrl_line_three
                          & iface_ctrl_line_five & iface_ctrl_line_six;
    assign sel_aux_b      = dir_out & iface_ctrl_line_two
                          & iface_ctrl_line_three & iface_ctrl_line_six;

    // Only select and strobe gate the command into the latch
    assign cmd_write_go  = sel_cmd_write & ctrl_strobe;
    assign sense_read_go = sel_sense_read & ctrl_strobe;
    assign ack_go        = ctrl_strobe
                         & (sel_cmd_write | sel_sense_read | sel_aux_a | sel_aux_b);

    ////////////////////////////////////////////////////////////////////////////
    // Command decode of the live data lines
    logic dec_motion;                               // Motion level for these lines
    logic dec_direction;                            // Direction level
    logic dec_head;                                 // Head mode level
    logic dec_aux;                                  // Auxiliary level

    tdc_decode u_decode (
        .cmd       (cmd_lines),
        .motion    (dec_motion),
        .direction (dec_direction),
        .head_mode (dec_head),
        .aux       (dec_aux)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command latch and drive outputs
    logic [CMD_W-1:0] cmd_q;                        // Latched command
    logic [CMD_W-1:0] cmd_d;                        // Next latched command
    logic             motion_q;                     // Motion output flop
    logic             motion_d;
    logic             dir_q;                        // Direction output flop
    logic             dir_d;
    logic             head_q;                       // Head mode output flop
    logic             head_d;
    logic             aux_q;                        // Auxiliary output flop
    logic             aux_d;

    // Load on a qualified write, otherwise hold
    assign cmd_d    = cmd_write_go ? cmd_lines     : cmd_q;
    assign motion_d = cmd_write_go ? dec_motion    : motion_q;
    assign dir_d    = cmd_write_go ? dec_direction : dir_q;
    assign head_d   = cmd_write_go ? dec_head      : head_q;
    assign aux_d    = cmd_write_go ? dec_aux       : aux_q;

    // Reset leaves the drive commanded still
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_q    <= CMD_RESET;
            motion_q <= 1'b1;
            dir_q    <= 1'b0;
            head_q   <= 1'b0;
            aux_q    <= 1'b0;
        end else begin
            cmd_q    <= cmd_d;
            motion_q <= motion_d;
            dir_q    <= dir_d;
            head_q   <= head_d;
            aux_q    <= aux_d;
        end
    end

    assign tape_motion_command   = motion_q;
    assign tape_direction_select = dir_q;
    assign tape_head_mode        = head_q;
    assign tape_aux_decode       = aux_q;

    ////////////////////////////////////////////////////////////////////////////
    // Drive sense read-back onto the data lines
    logic [DATA_W-1:0] sense_word;                  // Sense bits at their lines
    logic [DATA_W-1:0] dout_q;                      // Data lines value
    logic [DATA_W-1:0] dout_d;
    logic [DATA_W-1:0] oe_n_q;                      // Data lines enables
    logic [DATA_W-1:0] oe_n_d;

    // Position on line four, other sense bits above it
    always_comb begin
        sense_word            = '0;
        sense_word[POS_LINE]  = tape_position;
        sense_word[WINH_LINE] = write_inhibit;
        sense_word[SIDE_LINE] = side_select;
        sense_word[LOAD_LINE] = cassette_loaded;
    end

    // Drive only while the host reads with the sense select
    assign dout_d = sense_read_go ? sense_word : '0;
    assign oe_n_d = sense_read_go ? SENSE_OE_N : '1;

    always_ff @(posedge clk) begin
        if (reset) begin
            dout_q <= '0;
            oe_n_q <= '1;                           // Released after reset
        end else begin
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign data_line_out  = dout_q;
    assign data_line_oe_n = oe_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge
    logic ack_q;                                    // Acknowledge flop
    logic ack_d;
    logic ack_en;                                   // Control enable

    assign ack_d = ack_go & ack_en;

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    assign ack = ack_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode
    logic hit_ctrl;                                 // Address is control
    logic hit_status;                               // Address is status
    logic hit_count;                                // Address is counter
    logic wr_ctrl;                                  // Control write

    assign hit_ctrl   = reg_addr == CTRL_OFS;
    assign hit_status = reg_addr == STATUS_OFS;
    assign hit_count  = reg_addr == COUNT_OFS;
    assign wr_ctrl    = reg_write & hit_ctrl;

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    logic [1:0] ctrl_q;                             // Enables
    logic [1:0] ctrl_d;
    logic       cnt_clear;                          // Counter clear pulse
    logic       cnt_en;                             // Counting enabled

    assign ctrl_d    = wr_ctrl ? reg_wdata[CTRL_ACK_EN_BIT:CTRL_CNT_EN_BIT] : ctrl_q;
    assign cnt_clear = wr_ctrl & reg_wdata[CTRL_CLR_BIT];
    assign cnt_en    = ctrl_q[CTRL_CNT_EN_BIT];
    assign ack_en    = ctrl_q[CTRL_ACK_EN_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Qualified write counter: one count per strobe, not per clock
    logic             strobe_q;                     // Strobe one clock ago
    logic             write_start;                  // First clock of a write
    logic [CNT_W-1:0] cnt_q;                        // Write count
    logic [CNT_W-1:0] cnt_d;

    assign write_start = cmd_write_go & ~strobe_q;

    // A new write in the clear cycle still counts once
    always_comb begin
        if (cnt_clear) begin
            cnt_d = (write_start & cnt_en) ? CNT_W'(1) : '0;
        end else if (write_start & cnt_en) begin
            cnt_d = cnt_q + CNT_W'(1);              // Wraps at the top
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            strobe_q <= 1'b0;
            cnt_q    <= '0;
        end else begin
            strobe_q <= ctrl_strobe;
            cnt_q    <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux
    logic [REG_W-1:0] status_word;                  // Status assembly
    logic [REG_W-1:0] rd_mux;                       // Selected word
    logic [REG_W-1:0] rdata_q;                      // Read data flop
    logic [REG_W-1:0] rdata_d;

    always_comb begin
        status_word                                = '0;
        status_word[ST_CMD_LSB +: CMD_W]           = cmd_q;
        status_word[ST_MOTION_BIT]                 = motion_q;
        status_word[ST_DIR_BIT]                    = dir_q;
        status_word[ST_HEAD_BIT]                   = head_q;
        status_word[ST_AUX_BIT]                    = aux_q;
        status_word[ST_POS_BIT]                    = tape_position;
        status_word[ST_WINH_BIT]                   = write_inhibit;
        status_word[ST_SIDE_BIT]                   = side_select;
        status_word[ST_LOAD_BIT]                   = cassette_loaded;
    end

    // Unmapped addresses read zero
    assign rd_mux = hit_ctrl   ? {{(REG_W-2){1'b0}}, ctrl_q} :
                    hit_status ? status_word :
                    hit_count  ? {{(REG_W-CNT_W){1'b0}}, cnt_q} : '0;

    // Data stand for one cycle after the read strobe, zero otherwise
    assign rdata_d = reg_read ? rd_mux : '0;

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// ==== tb/tdc_latch_assertions.sv ====
// Concurrent checks on the tape command latch top-level pins.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/1ns
`default_nettype none

module tdc_latch_checker
    import tdc_pkg::*;
(
    input wire logic              clk,                   // Clock
    input wire logic              reset,                 // Sync reset, high
    input wire logic              dir_out,               // Host direction
    input wire logic              iface_ctrl_line_zero,  // Select 0
    input wire logic              iface_ctrl_line_one,   // Select 1
    input wire logic              iface_ctrl_line_five,  // Select 5
    input wire logic              iface_ctrl_line_six,   // Select 6
    input wire logic              ctrl_strobe,           // Write strobe
    input wire logic [DATA_W-1:0] data_line_in,          // Lines as seen
    input wire logic [DATA_W-1:0] data_line_out,         // Lines driven value
    input wire logic [DATA_W-1:0] data_line_oe_n,        // Low: driven
    input wire logic              tape_position,         // Position sense
    input wire logic              tape_motion_command,   // Motion level
    input wire logic              tape_direction_select, // Direction level
    input wire logic              tape_head_mode,        // Head mode level
    input wire logic              tape_aux_decode        // Auxiliary level
);
    ////////////////////////////////////////////////////////////////////////////
    // Qualified host cycles
    wire logic             wr_sel = dir_out & iface_ctrl_line_zero & iface_ctrl_line_five
                                    & iface_ctrl_line_six & ctrl_strobe; // Command write
    wire logic             rd_sel = ~dir_out & iface_ctrl_line_one & iface_ctrl_line_five
                                    & iface_ctrl_line_six & ctrl_strobe; // Sense read
    wire logic [CMD_W-1:0] cmd_in = data_line_in[CMD_W-1:0];             // Command lines
    wire logic [3:0]       drv_v  = {tape_motion_command, tape_direction_select,
                                     tape_head_mode, tape_aux_decode};   // All drive levels

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    // Decode and hold
    motion_decode_a: assert property (wr_sel |=>
        tape_motion_command == ($past(cmd_in) != 4'h4)) else $error("motion wrong");
    dir_decode_a: assert property (wr_sel |=>
        tape_direction_select == ($past(cmd_in) == 4'h2)) else $error("direction wrong");
    head_decode_a: assert property (wr_sel |=> tape_head_mode == ($past(cmd_in) == 4'h1))
        else $error("head mode wrong");
    aux_decode_a: assert property (wr_sel |=> tape_aux_decode == ($past(cmd_in) == 4'h8))
        else $error("aux wrong");
    drive_hold_a: assert property (!wr_sel |=> $stable(drv_v))
        else $error("drive moved unasked");
    reset_stop_a: assert property ($fell(reset) |-> tape_motion_command && !tape_head_mode)
        else $error("not stopped after reset");

    ////////////////////////////////////////////////////////////////////////////
    // Sense read-back
    sense_read_a: assert property (rd_sel |=> !data_line_oe_n[4]
        && data_line_out[4] == $past(tape_position)) else $error("position not on line four");
    sense_release_a: assert property (!rd_sel |=> data_line_oe_n == 8'hFF)
        else $error("lines driven outside read");
endmodule

bind tdc_latch tdc_latch_checker u_chk (.*);
`default_nettype wire

// ==== tb/tdc_drive_model.sv ====
// Behavioural cassette drive: moves tape only while motion is low.
// Assumes the bench sets the cassette and sense switches.
`timescale 1ns/1ns
`default_nettype none

module tdc_drive_model (
    input  wire logic clk,                   // Clock
    input  wire logic loaded_in,             // Cassette in place
    input  wire logic inh_in,                // Write inhibit switch
    input  wire logic side_in,               // Side switch
    input  wire logic tape_motion_command,   // High: hold tape still
    input  wire logic tape_direction_select, // High: rewind
    output logic      tape_position,         // At start of tape
    output logic      write_inhibit,         // Inhibit sense
    output logic      side_select,           // Side sense
    output logic      cassette_loaded        // Loaded sense
);
    int pos = 0; // Tape position, zero at start

    // Tape travel; stationary while motion is high
    always @(posedge clk) begin
        if (loaded_in && !tape_motion_command) begin
            pos <= tape_direction_select ? ((pos > 0) ? pos - 1 : 0) : pos + 1;
        end
    end
    assign tape_position   = loaded_in && (pos == 0);
    assign write_inhibit   = inh_in;
    assign side_select     = side_in;
    assign cassette_loaded = loaded_in;
endmodule
`default_nettype wire

// ==== tb/tb_tdc_latch.sv ====
// Self-checking bench for the tape command latch.
// Assumes a 100 MHz clock and the drive model on the far side.
`timescale 1ns/1ns
`default_nettype none

module tb_tdc_latch
    import tdc_pkg::*;
;
    logic              clk = 1'b0;       // Clock
    logic              reset = 1'b1;     // Sync reset
    logic              dir_out = 1'b0;   // Host direction
    logic [5:0]        ic = 6'h00;       // Selects 0,1,2,3,5,6
    logic              ctrl_strobe = 1'b0; // Host strobe
    logic [DATA_W-1:0] host_d = 8'h00;   // Host drive on lines
    logic [ADDR_W-1:0] reg_addr = 8'h00; // Register address
    logic [REG_W-1:0]  reg_wdata = 32'h0; // Register write data
    logic              reg_write = 1'b0; // Register write strobe
    logic              reg_read = 1'b0;  // Register read strobe
    logic              loaded = 1'b1, inh = 1'b0, side = 1'b0; // Drive switches
    wire logic [DATA_W-1:0] d_out, d_oe_n, d_wire; // Data line parts
    wire logic [REG_W-1:0]  rdata;       // Register read data
    wire logic motion, dirsel, head, aux, pos_s, inh_s, side_s, load_s, ack_s; // Pins
    int err_total = 0;                   // Mismatches
    int num_checks = 0;                  // Comparisons
    int exp_cmd = 0;                     // Model: latched command
    int wr_log[$];                       // Model: accepted commands

    always #5 clk = ~clk;
    // Design wins where it drives
    assign d_wire = (d_out & ~d_oe_n) | (host_d & d_oe_n);

    tdc_latch i_dut (.clk(clk), .reset(reset), .dir_out(dir_out),
        .iface_ctrl_line_zero(ic[0]), .iface_ctrl_line_one(ic[1]), .iface_ctrl_line_two(ic[2]),
        .iface_ctrl_line_three(ic[3]), .iface_ctrl_line_five(ic[4]), .iface_ctrl_line_six(ic[5]),
        .ctrl_strobe(ctrl_strobe), .data_line_in(d_wire), .data_line_out(d_out),
        .data_line_oe_n(d_oe_n), .ack(ack_s), .tape_position(pos_s), .write_inhibit(inh_s),
        .side_select(side_s), .cassette_loaded(load_s), .tape_motion_command(motion),
        .tape_direction_select(dirsel), .tape_head_mode(head), .tape_aux_decode(aux),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(rdata));
    tdc_drive_model i_drv (.clk(clk), .loaded_in(loaded), .inh_in(inh), .side_in(side),
        .tape_motion_command(motion), .tape_direction_select(dirsel), .tape_position(pos_s),
        .write_inhibit(inh_s), .side_select(side_s), .cassette_loaded(load_s));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and closing tasks
    task automatic chk_word(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Host strobe cycle
    task automatic host(input logic wr, input logic [5:0] sel, input logic [3:0] d);
        logic exp_ack; // Ack due
        exp_ack = wr ? (sel == 6'h31 || sel == 6'h2C) : (sel == 6'h32 || sel == 6'h38);
        @(posedge clk);
        dir_out <= wr;
        ic <= sel;
        host_d <= {4'h0, d};
        ctrl_strobe <= 1'b1;
        @(posedge clk);
        ctrl_strobe <= 1'b0;
        ic <= 6'h00;
        #1;
        chk_word({31'h0, ack_s}, {31'h0, exp_ack});
        if (wr && sel == 6'h31) begin
            exp_cmd = d;
            wr_log.push_back(d);
        end
        if (!wr && sel == 6'h32) begin
            chk_word({24'h0, d_oe_n}, 32'h0F);
            chk_word({28'h0, d_out[7:4]}, {28'h0, load_s, side_s, inh_s, pos_s});
        end
        @(posedge clk);
        #1;
    endtask
    // Drive pins vs model
    task automatic chk_drive();
        chk_word({31'h0, motion}, {31'h0, exp_cmd != 4});
        chk_word({31'h0, dirsel}, {31'h0, exp_cmd == 2});
        chk_word({31'h0, head}, {31'h0, exp_cmd == 1});
        chk_word({31'h0, aux}, {31'h0, exp_cmd == 8});
    endtask
    // Register port cycles
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk_word(rdata, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int pat[$];
        void'($urandom(88149));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk_drive();
        host(1'b0, 6'h32, 4'h0);
        pat = '{0, 1, 2, 4, 8};
        repeat (6) pat.push_back($urandom % 16);
        foreach (pat[i]) begin
            host(1'b1, 6'h31, pat[i][3:0]);
            chk_drive();
            host(1'b1, 6'h21, $urandom % 16);
            host(1'b0, 6'h31, $urandom % 16);
            host(1'b1, 6'h2C, $urandom % 16);
            host(1'b0, 6'h38, $urandom % 16);
            chk_drive();
        end
        host(1'b1, 6'h31, 4'h0);
        inh <= 1'b1;
        side <= 1'b1;
        host(1'b0, 6'h32, 4'h0);
        chk_word({24'h0, d_oe_n}, 32'hFF);
        reg_rd(STATUS_OFS, {20'h0, load_s, side_s, inh_s, pos_s, 8'h10});
        reg_rd(COUNT_OFS, wr_log.size());
        reg_wr(CTRL_OFS, 32'h7);
        reg_rd(COUNT_OFS, 32'h0);
        reg_rd(CTRL_OFS, 32'h3);
        reg_rd(8'h0C, 32'h0);
        end_sim();
    end

    // Watchdog against a hang
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
